// [verilog/port0_pin_function_select.sv]
// port 0 pin function select with avalon-mm registers, plus reset state of groups 11 and 12
// assumes pins synchronous to ref_clk; pads resolved outside from out/oe
//
// Functional notes
// - the port has eight pins, each with its own direction bit.
// - direction comes from the direction register on port mode pins only, and function from mode control plus select.
// - in control mode pins 0 and 1 carry the two timer channel zero outputs.
// - in control mode pin 2 feeds timer clear and pin 3 feeds timer count.
// - in control mode pins 4 to 7 feed either interrupt requests or dma requests.
// - interrupt requests pass a noise filter and an edge detector first.
// - after reset every group 11 pin is a general input.
// - after reset every group 12 pin is a general input.
// - mode control 0 gives port use on pins 4 to 7, 1 gives the control function.
// - select 0 gives interrupt request, select 1 gives dma request.
// - the select bit has no effect on a pin in port mode.
`timescale 1ns/1ps
`include "port0_consts.svh"
module port0_pin_function_select #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned FILT_LEN = `FILT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    input wire logic pulse_timer_out_a,
    input wire logic pulse_timer_out_b,
    output logic pulse_timer_clear_in,
    output logic pulse_timer_count_in,
    output logic [3:0] ext_irq_pulse,
    output logic [3:0] dma_request_level,
    output logic [7:0] group11_oe,
    output logic [7:0] group12_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [WIDTH-1:0] port_latch_r;
    logic [WIDTH-1:0] port_direction_reg;
    logic [WIDTH-1:0] port_mode_control_reg;
    logic [WIDTH-1:0] control_select_reg;
    logic [31:0] rdata_r;
    port0_pkg::bus_state_t state_r;
    port0_pkg::bus_state_t state_nxt;

    // every access takes one wait cycle so read data always come from a flop
    wire take = (avs_read | avs_write) && (state_r == port0_pkg::bus_idle);
    // a write lands only at the edge that answers it, never while the master still waits
    wire accept = (avs_read | avs_write) && (state_r == port0_pkg::bus_ack);
    wire wr_en = avs_write && accept && avs_byteenable[0];
    wire sel_data = (avs_address == `OFS_PORT_DATA);
    wire sel_dir = (avs_address == `OFS_PORT_DIR);
    wire sel_mode = (avs_address == `OFS_PORT_MODE_CTRL);
    wire sel_csel = (avs_address == `OFS_CTRL_SELECT);
    wire [7:0] wbyte = avs_writedata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // pin function decode
    wire [WIDTH-1:0] ctrl_mode = port_mode_control_reg;
    // select only matters where mode control picks the control function
    wire [3:0] irq_sel = ctrl_mode[7:4] & ~control_select_reg[7:4];
    wire [3:0] dma_sel = ctrl_mode[7:4] & control_select_reg[7:4];
    wire [WIDTH-1:0] ctrl_oe = {6'h00, ctrl_mode[1:0]};
    wire [WIDTH-1:0] ctrl_val = {6'h00, pulse_timer_out_b, pulse_timer_out_a};
    // direction bit 1 means input, one bit per pin
    wire [WIDTH-1:0] port_oe = ~ctrl_mode & ~port_direction_reg;
    wire [WIDTH-1:0] read_back =
        (port_direction_reg & pin_in) | (~port_direction_reg & port_latch_r);

    assign pin_oe = port_oe | ctrl_oe;
    assign pin_out = (ctrl_mode & ctrl_val) | (~ctrl_mode & port_latch_r);
    assign pulse_timer_clear_in = ctrl_mode[2] & pin_in[2];
    assign pulse_timer_count_in = ctrl_mode[3] & pin_in[3];
    assign dma_request_level = dma_sel & pin_in[7:4];
    // groups 11 and 12 stay general inputs: their output enables are held low
    assign group11_oe = 8'h00;
    assign group12_oe = 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_irq
            irq_pin_filter #(.FILT_LEN(FILT_LEN)) u_filt (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .enable(irq_sel[gi]),
                .pin_in(pin_in[gi+4]),
                .level_out(),
                .edge_pulse(ext_irq_pulse[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    wire [7:0] rd_byte =
        sel_data ? read_back :
        sel_dir ? port_direction_reg :
        sel_mode ? port_mode_control_reg :
        sel_csel ? control_select_reg : 8'h00;

    // the spare state codes fall back to idle
    always_comb
    begin
        state_nxt = port0_pkg::bus_idle;
        unique case (state_r)
            port0_pkg::bus_idle:
            begin
                if (avs_read | avs_write)
                    state_nxt = port0_pkg::bus_ack;
            end
            port0_pkg::bus_ack:
            begin
                state_nxt = port0_pkg::bus_idle;
            end
            default:
            begin
                state_nxt = port0_pkg::bus_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_latch_r <= `RST_PORT_DATA;
            port_direction_reg <= `RST_PORT_DIR;
            port_mode_control_reg <= `RST_PORT_MODE_CTRL;
            control_select_reg <= `RST_CTRL_SELECT;
            rdata_r <= 32'h0000_0000;
            state_r <= port0_pkg::bus_idle;
        end
        else
        begin
            state_r <= state_nxt;
            if (take)
                rdata_r <= {24'h00_0000, rd_byte};
            if (wr_en && sel_data)
                port_latch_r <= wbyte;
            if (wr_en && sel_dir)
                port_direction_reg <= wbyte;
            if (wr_en && sel_mode)
                port_mode_control_reg <= wbyte;
            if (wr_en && sel_csel)
                control_select_reg <= wbyte & `CTRL_SELECT_MASK;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) && (state_r == port0_pkg::bus_idle);
    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    timer_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_mode[0] |-> pin_oe[0] && pin_out[0] == pulse_timer_out_a)
        else $error("pin 0 not driven by timer output a");
    timer_out_b_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_mode[1] |-> pin_oe[1] && pin_out[1] == pulse_timer_out_b)
        else $error("pin 1 not driven by timer output b");
    timer_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_mode[3] |-> pulse_timer_count_in == pin_in[3])
        else $error("timer count input not routed");
    count_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !ctrl_mode[3] |-> !pulse_timer_count_in)
        else $error("timer count input active in port mode");
    clear_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_mode[2] |-> pulse_timer_clear_in == pin_in[2])
        else $error("timer clear input not routed");
    clear_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !ctrl_mode[2] |-> !pulse_timer_clear_in)
        else $error("timer clear input active in port mode");
    ctrl_inputs_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_mode[7:2] & pin_oe[7:2]) == 6'h00)
        else $error("control input pin driven");
    sel_ignored_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !ctrl_mode[7] |-> !dma_request_level[3] && !pin_oe[7] == port_direction_reg[7])
        else $error("select bit acted on a port mode pin");
    dma_port_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (dma_request_level & ~ctrl_mode[7:4]) == 4'h0)
        else $error("dma request from a port mode pin");
    dma_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_mode[4] && control_select_reg[4]) |-> dma_request_level[0] == pin_in[4])
        else $error("dma request not routed");
    dma_select_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (dma_request_level & ~control_select_reg[7:4]) == 4'h0)
        else $error("dma request from an interrupt pin");
    irq_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ext_irq_pulse & ~$past(irq_sel)) == 4'h0)
        else $error("interrupt pulse from a pin not in interrupt mode");
    select_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        control_select_reg[3:0] == 4'h0)
        else $error("fixed select bits not zero");
    port_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!ctrl_mode[5] && !port_direction_reg[5]) |-> pin_oe[5] && pin_out[5] == port_latch_r[5])
        else $error("port output not driven from latch");
    port_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (take && sel_data && port_direction_reg[6]) |=> avs_readdata[6] == $past(pin_in[6]))
        else $error("input pin level not read back");
    dir_input_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (port_direction_reg[4] && !ctrl_mode[4]) |-> !pin_oe[4])
        else $error("input pin driven");
    groups_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        group11_oe == 8'h00 && group12_oe == 8'h00)
        else $error("group 11 or 12 pin driven");
    wr_dir_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (avs_write && !avs_waitrequest && sel_dir && avs_byteenable[0])
        |=> port_direction_reg == $past(wbyte))
        else $error("direction write lost");
    wr_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (avs_write && avs_waitrequest && sel_mode)
        |=> port_mode_control_reg == $past(port_mode_control_reg))
        else $error("mode write landed before the answer");
    ack_once_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        take |=> !avs_waitrequest)
        else $error("bus access not answered in one cycle");
endmodule // port0_pin_function_select

// [verilog/port0_consts.svh]
// constants for the port 0 pin function block: offsets, reset values, timing counts
// assumes a 32-bit avalon-mm register bus with word addressing in bytes
`ifndef PORT0_CONSTS_SVH
`define PORT0_CONSTS_SVH
`define OFS_PORT_DATA 4'h0
`define OFS_PORT_DIR 4'h4
`define OFS_PORT_MODE_CTRL 4'h8
`define OFS_CTRL_SELECT 4'hc
`define RST_PORT_DATA 8'h00
`define RST_PORT_DIR 8'hff
`define RST_PORT_MODE_CTRL 8'h00
`define RST_CTRL_SELECT 8'h00
`define CTRL_SELECT_MASK 8'hf0
`define FILT_TIME_NS 75
`define CLK_PERIOD_NS 25
`define FILT_CYCLES ((`FILT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [verilog/port0_pkg.sv]
// types for the port 0 pin function block
// assumes nothing of its surroundings
package port0_pkg;
    typedef enum logic [1:0] {bus_idle, bus_ack} bus_state_t;
endpackage

// [verilog/irq_pin_filter.sv]
// noise filter and edge detector for one external interrupt request pin
// assumes the pin is synchronous to ref_clk
`timescale 1ns/1ps
`include "port0_consts.svh"
module irq_pin_filter #(
    parameter int unsigned FILT_LEN = `FILT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic pin_in,
    output logic level_out,
    output logic edge_pulse
);
    logic [FILT_LEN-1:0] hist_r;
    logic level_r;
    logic pulse_r;
    wire all_high = &hist_r;
    wire all_low = ~|hist_r;
    // a level change is only accepted once it has stood for the whole window
    wire level_nxt = all_high ? 1'b1 : (all_low ? 1'b0 : level_r);
    wire rise = level_nxt & ~level_r & enable;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hist_r <= '0;
            level_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else
        begin
            hist_r <= {hist_r[FILT_LEN-2:0], pin_in & enable};
            level_r <= level_nxt;
            pulse_r <= rise;
        end
    end

    assign level_out = level_r;
    assign edge_pulse = pulse_r;

    filt_edge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        edge_pulse |-> $past(all_high) && !$past(level_r))
        else $error("edge pulse without a settled rising level");
endmodule // irq_pin_filter

// [testbench/pin_far_side.sv]
// far side of port 0: the pads
// assumes pin_oe high means the block drives the pad
`timescale 1ns/1ps
module pin_far_side (
    input wire logic [7:0] ext_level,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_in
);
    // a driven pad reads back the block's own value, otherwise the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_far_side

// [testbench/port0_pin_function_select_tb.sv]
// scenario bench for the port 0 pin function block
// assumes FILT_LEN 3, so a filtered interrupt edge shows within a few cycles
`timescale 1ns/1ps
module port0_pin_function_select_tb;
    logic ref_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ta = 1'b0, tb = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h1, irq, dma;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, clr, cnt;
    logic [7:0] ext = 8'h00, pin_in, pin_out, pin_oe, g11, g12;
    int n_fail = 0, n_compared = 0;
    port0_pin_function_select u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pulse_timer_out_a(ta), .pulse_timer_out_b(tb),
        .pulse_timer_clear_in(clr), .pulse_timer_count_in(cnt), .ext_irq_pulse(irq),
        .dma_request_level(dma), .group11_oe(g11), .group12_oe(g12));
    pin_far_side u_far (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    initial forever #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one edge passes first, so a release and the next request never share a step
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h00_0000, d};
        // no cycle count is assumed: the wait ends when avs_waitrequest drops, or at the watchdog
        do
        begin
            @(posedge ref_clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // a write lands at the answering edge, so one more edge passes before judging
        @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("group11_oe", g11, 32'h0);
        chk("group12_oe", g12, 32'h0);
        chk("pin_oe", pin_oe, 32'h0);
        bus(4'h4, 1'b0, 8'h00);
        chk("direction", q, 32'hff);
        bus(4'h8, 1'b0, 8'h00);
        chk("mode", q, 32'h0);
        bus(4'hc, 1'b0, 8'h00);
        chk("select", q, 32'h0);
        bus(4'h2, 1'b0, 8'h00);
        chk("unmapped", q, 32'h0);
    endtask
    task automatic t_port_io;
        ext <= 8'h90;
        bus(4'h0, 1'b1, 8'ha5);
        bus(4'h4, 1'b1, 8'hf0);
        chk("pin_oe", pin_oe, 32'h0f);
        chk("pin_out", pin_out & 8'h0f, 32'h05);
        // a write with its low byte lane off must leave the latch alone
        avs_byteenable <= 4'h0;
        bus(4'h0, 1'b1, 8'hff);
        avs_byteenable <= 4'h1;
        bus(4'h0, 1'b0, 8'h00);
        chk("data", q, 32'h95);
    endtask
    task automatic t_timer_pins;
        ta <= 1'b1;
        ext <= 8'h04;
        bus(4'h8, 1'b1, 8'h0f);
        chk("timer pins", pin_out & 8'h03, 32'h01);
        chk("timer oe", pin_oe, 32'h03);
        chk("clear", clr, 32'h1);
        chk("count", cnt, 32'h0);
        ta <= 1'b0;
        tb <= 1'b1;
        ext <= 8'h08;
        @(posedge ref_clk);
        chk("timer pins", pin_out & 8'h03, 32'h02);
        chk("clear", clr, 32'h0);
        chk("count", cnt, 32'h1);
    endtask
    task automatic t_request_pins;
        int n;
        ext <= 8'ha0;
        bus(4'hc, 1'b1, 8'hff); // select high first, so no interrupt edge yet
        bus(4'h8, 1'b1, 8'hf0);
        bus(4'hc, 1'b0, 8'h00);
        chk("select", q, 32'hf0);
        chk("dma", dma, 32'ha);
        ext <= 8'h00;
        bus(4'hc, 1'b1, 8'h00);
        chk("dma off", dma, 32'h0);
        ext <= 8'h10;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (irq === 4'h0 && n < 10);
        chk("irq", irq, 32'h1);
        @(posedge ref_clk);
        chk("irq one cycle", irq, 32'h0);
        ext <= 8'h00;
        bus(4'hc, 1'b1, 8'hf0);
        bus(4'h8, 1'b1, 8'h00);
        ext <= 8'hf0;
        repeat (8) @(posedge ref_clk);
        chk("port mode dma", dma, 32'h0);
        // with select back at interrupt, a port mode pin must still raise no pulse
        bus(4'hc, 1'b1, 8'h00);
        n = 0;
        repeat (8)
        begin
            @(posedge ref_clk);
            if (irq !== 4'h0)
                n++;
        end
        chk("port mode irq", n, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_port_io();
        t_timer_pins();
        t_request_pins();
        report_and_stop();
    end
    initial
    begin
        #50000;
        n_fail++;
        report_and_stop();
    end
endmodule // port0_pin_function_select_tb
